// ===== core/axil_regs.sv
`timescale 1ns/100ps
`include "i2c_slave_cfg.svh"

// ============================================================
// AXI4-Lite slave front end: one write and one read at a time
// ============================================================
module axil_regs (
  // Clock and reset
  input wire logic mclk,
  input wire logic rstn,
  // Write address and data
  input wire logic [4:0] awaddr,
  input wire logic awvalid,
  output logic awready,
  input wire logic [31:0] wdata,
  input wire logic [3:0] wstrb,
  input wire logic wvalid,
  output logic wready,
  // Write response
  output logic [1:0] bresp,
  output logic bvalid,
  input wire logic bready,
  // Read address and data
  input wire logic [4:0] araddr,
  input wire logic arvalid,
  output logic arready,
  output logic [31:0] rdata,
  output logic [1:0] rresp,
  output logic rvalid,
  input wire logic rready,
  // Core side
  output logic wr_stb,
  output logic [4:0] wr_addr,
  output logic [7:0] wr_data,
  output logic rd_stb,
  output logic [4:0] rd_addr,
  input wire logic [7:0] rd_data,
  input wire logic rd_ok,
  input wire logic wr_ok
);

  logic aw_held;
  logic w_held;
  logic [4:0] aw_q;
  logic [7:0] w_q;
  logic w_lane;

  // Address and data are taken in either order, then acted on once
  assign awready = !aw_held && !bvalid;
  assign wready = !w_held && !bvalid;
  assign wr_stb = aw_held && w_held && !bvalid;
  assign wr_addr = aw_q;
  assign wr_data = w_q;
  assign arready = !rvalid;
  assign rd_stb = arvalid && !rvalid;
  assign rd_addr = araddr;

  // Write path; byte lane 0 strobe is recorded, but a write without it still goes ahead
  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      aw_held <= 1'b0;
      w_held <= 1'b0;
      aw_q <= 5'h00;
      w_q <= 8'h00;
      w_lane <= 1'b0;
      bvalid <= 1'b0;
      bresp <= `AXI_OKAY;
    end else begin
      if (awvalid && awready) begin
        aw_held <= 1'b1;
        aw_q <= awaddr;
      end
      if (wvalid && wready) begin
        w_held <= 1'b1;
        w_q <= wdata[7:0];
        w_lane <= wstrb[0];
      end
      if (wr_stb) begin
        aw_held <= 1'b0;
        w_held <= 1'b0;
        bvalid <= 1'b1;
        bresp <= wr_ok ? `AXI_OKAY : `AXI_SLVERR;
      end else if (bvalid && bready) begin
        bvalid <= 1'b0;
      end
    end
  end

  // Read path: one cycle from address to data
  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      rvalid <= 1'b0;
      rdata <= 32'h0000_0000;
      rresp <= `AXI_OKAY;
    end else if (rd_stb) begin
      rvalid <= 1'b1;
      rdata <= {24'h00_0000, rd_data};
      rresp <= rd_ok ? `AXI_OKAY : `AXI_SLVERR;
    end else if (rvalid && rready) begin
      rvalid <= 1'b0;
    end
  end

  logic unused_lane;
  assign unused_lane = w_lane;

endmodule : axil_regs

// ===== core/i2c_slave_cfg.svh
`ifndef I2C_SLAVE_CFG_SVH
`define I2C_SLAVE_CFG_SVH

// Register byte offsets on the AXI4-Lite bus
`define OFS_CTRL 4'h0
`define OFS_STAT 4'h4
`define OFS_ADDR 4'h8
`define OFS_DATA 4'hC
`define OFS_TOUT 5'h10

// module_control_reg fields
`define CTRL_MODE_HI 7
`define CTRL_MODE_LO 5
`define CTRL_DEB_HI 3
`define CTRL_DEB_LO 2
`define CTRL_EN 1
`define CTRL_RESET 8'hE0
`define MODE_I2C_SLAVE 3'h6

// bus_status_control fields
`define ST_DONE 7
`define ST_MATCH 6
`define ST_BUSY 5
`define ST_TX 4
`define ST_ACKOUT 3
`define ST_DIR 2
`define ST_WAKE 1
`define ST_ACKIN 0
`define STAT_RESET 8'h81

// Timeout register: bit 6 is the sticky timeout flag
`define TOUT_FLAG 6

// Debounce lengths in system clocks
`define DEB_SHORT 3'h2
`define DEB_LONG 3'h4

`define AXI_OKAY 2'h0
`define AXI_SLVERR 2'h2

`endif

// ===== core/i2c_slave_interface.sv
// Design decisions made here: the placing of the registers and the AXI4-Lite slave port.
`timescale 1ns/100ps
`include "i2c_slave_cfg.svh"

// ============================================================
// Two-wire slave interface
// ============================================================
// Notes on behaviour
// - Disabled module releases pins, idles logic
// - Enable works only with option strap set
// - Enable rise keeps controls, resets flags
// - Done flag low while shifting, set after byte
// - Match flag follows address comparison
// - Busy set on START, cleared on STOP
// - Transmit select chooses receive or transmit
// - Ack-out control driven on ninth receive clock
// - Bit after address captured as direction
// - Address match wakes device when enabled
// - Master ack sampled on ninth transmit clock
// - Transmitter stops and releases on no-ack
// - Seven-bit address MSB first, compared, interrupt
// - Matched address acknowledged low, flag set
// - Clock held low until data access
// - One interrupt for match, done, timeout; the timeout flag is never set here, so only match and done raise it
// - Active with mode 110 and enable set
// - Own address bits 7..1, bit 0 zero
// - Clock debounce of 0, 2 or 4 clocks
// - Bytes eight bits MSB first, acked low
module i2c_slave_interface (
  // Clock and reset
  input wire logic mclk,
  input wire logic rstn,
  // Configuration option strap
  input wire logic option_enable,
  // AXI4-Lite write address and data
  input wire logic [4:0] awaddr,
  input wire logic awvalid,
  output logic awready,
  input wire logic [31:0] wdata,
  input wire logic [3:0] wstrb,
  input wire logic wvalid,
  output logic wready,
  // AXI4-Lite write response
  output logic [1:0] bresp,
  output logic bvalid,
  input wire logic bready,
  // AXI4-Lite read
  input wire logic [4:0] araddr,
  input wire logic arvalid,
  output logic arready,
  output logic [31:0] rdata,
  output logic [1:0] rresp,
  output logic rvalid,
  input wire logic rready,
  // Bus clock pin (open drain)
  input wire logic scl_in,
  output logic scl_out,
  output logic scl_oe,
  // Bus data pin (open drain)
  input wire logic sda_in,
  output logic sda_out,
  output logic sda_oe,
  // System signals
  output logic bus_irq,
  output logic wake_req,
  output logic low_power
);

  // ==========================================================
  // Registers and bus front end
  // ==========================================================
  logic [7:0] ctrl;
  logic [7:0] stat;
  logic [6:0] own_addr;
  logic [7:0] data_reg;
  logic tout_flag;
  logic wr_stb;
  logic [4:0] wr_addr;
  logic [7:0] wr_data;
  logic rd_stb;
  logic [4:0] rd_addr;
  logic [7:0] rd_data;
  logic rd_ok;
  logic wr_ok;

  axil_regs u_bus (
    .mclk(mclk), .rstn(rstn),
    .awaddr(awaddr), .awvalid(awvalid), .awready(awready),
    .wdata(wdata), .wstrb(wstrb), .wvalid(wvalid), .wready(wready),
    .bresp(bresp), .bvalid(bvalid), .bready(bready),
    .araddr(araddr), .arvalid(arvalid), .arready(arready),
    .rdata(rdata), .rresp(rresp), .rvalid(rvalid), .rready(rready),
    .wr_stb(wr_stb), .wr_addr(wr_addr), .wr_data(wr_data),
    .rd_stb(rd_stb), .rd_addr(rd_addr), .rd_data(rd_data),
    .rd_ok(rd_ok), .wr_ok(wr_ok)
  );

  // Address decode
  wire wr_ctrl = wr_stb && wr_addr == {1'b0, `OFS_CTRL};
  wire wr_stat = wr_stb && wr_addr == {1'b0, `OFS_STAT};
  wire wr_own = wr_stb && wr_addr == {1'b0, `OFS_ADDR};
  wire wr_dat = wr_stb && wr_addr == {1'b0, `OFS_DATA};
  wire wr_tout = wr_stb && wr_addr == `OFS_TOUT;
  wire rd_dat = rd_stb && rd_addr == {1'b0, `OFS_DATA};
  assign wr_ok = wr_ctrl | wr_stat | wr_own | wr_dat | wr_tout;
  assign rd_ok = rd_addr == {1'b0, `OFS_CTRL}
              || rd_addr == {1'b0, `OFS_STAT}
              || rd_addr == {1'b0, `OFS_ADDR}
              || rd_addr == {1'b0, `OFS_DATA}
              || rd_addr == `OFS_TOUT;

  // Read mux; unmapped addresses read zero with an error answer
  assign rd_data =
      (rd_addr == {1'b0, `OFS_CTRL}) ? {ctrl[7:5], 1'b0, ctrl[3:1], 1'b0} :
      (rd_addr == {1'b0, `OFS_STAT}) ? stat :
      (rd_addr == {1'b0, `OFS_ADDR}) ? {own_addr, 1'b0} :
      (rd_addr == {1'b0, `OFS_DATA}) ? data_reg :
      (rd_addr == `OFS_TOUT) ? {1'b0, tout_flag, 6'h00} : 8'h00;

  // Module is live only with strap, mode and enable all set
  wire en_bit = ctrl[`CTRL_EN];
  wire mode_ok = ctrl[`CTRL_MODE_HI:`CTRL_MODE_LO] == `MODE_I2C_SLAVE;
  wire active = option_enable && en_bit && mode_ok;
  assign low_power = !active;

  // Enable rising edge, seen through the effective enable
  logic active_q;
  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) active_q <= 1'b0;
    else active_q <= active;
  end
  wire en_rise = active && !active_q;

  // Debounce length select
  wire [1:0] deb_sel = ctrl[`CTRL_DEB_HI:`CTRL_DEB_LO];
  wire [2:0] deb_len = deb_sel[1] ? `DEB_LONG :
                       deb_sel[0] ? `DEB_SHORT : 3'h0;

  // ==========================================================
  // Pin conditioning and bus events
  // ==========================================================
  logic scl_f;
  logic sda_f;
  logic scl_d;
  logic sda_d;

  line_filter u_scl (
    .mclk(mclk), .rstn(rstn), .pin(scl_in),
    .deb_len(deb_len), .level(scl_f)
  );
  line_filter u_sda (
    .mclk(mclk), .rstn(rstn), .pin(sda_in),
    .deb_len(3'h0), .level(sda_f)
  );

  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      scl_d <= 1'b1;
      sda_d <= 1'b1;
    end else begin
      scl_d <= scl_f;
      sda_d <= sda_f;
    end
  end

  wire scl_rise = scl_f && !scl_d;
  wire scl_fall = !scl_f && scl_d;
  wire start_ev = active && scl_f && scl_d && sda_d && !sda_f;
  wire stop_ev = active && scl_f && scl_d && !sda_d && sda_f;

  // ==========================================================
  // Bit engine
  // ==========================================================
  i2c_slave_pkg::engine_state_t state;
  logic [7:0] shreg;
  logic [3:0] bitn;
  logic hold;
  logic sda_low;
  logic in_tx;

  wire addr_hit = shreg[7:1] == own_addr;
  wire tx_mode = stat[`ST_TX];
  wire acc_release = (wr_dat && tx_mode) || (rd_dat && !tx_mode);

  // Sequencer; a new START always restarts address reception
  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      state <= i2c_slave_pkg::ST_IDLE;
      shreg <= 8'h00;
      bitn <= 4'h0;
      hold <= 1'b0;
      sda_low <= 1'b0;
      in_tx <= 1'b0;
    end else if (!active || stop_ev) begin
      state <= i2c_slave_pkg::ST_IDLE;
      hold <= 1'b0;
      sda_low <= 1'b0;
    end else if (start_ev) begin
      state <= i2c_slave_pkg::ST_ADDR;
      bitn <= 4'h0;
      hold <= 1'b0;
      sda_low <= 1'b0;
    end else begin
      case (state)
        i2c_slave_pkg::ST_IDLE: begin
          sda_low <= 1'b0;
        end
        i2c_slave_pkg::ST_ADDR: begin
          if (scl_rise) begin
            shreg <= {shreg[6:0], sda_f};
            bitn <= bitn + 4'h1;
          end
          if (scl_fall && bitn == 4'h8) begin
            bitn <= 4'h0;
            if (addr_hit) begin
              state <= i2c_slave_pkg::ST_AACK;
              sda_low <= 1'b1;
            end else begin
              state <= i2c_slave_pkg::ST_IDLE;
            end
          end
        end
        i2c_slave_pkg::ST_AACK, i2c_slave_pkg::ST_DACK: begin
          if (scl_fall) begin
            sda_low <= 1'b0;
            if (state == i2c_slave_pkg::ST_DACK && in_tx && sda_f) begin
              state <= i2c_slave_pkg::ST_IDLE;
            end else begin
              state <= i2c_slave_pkg::ST_HOLD;
              hold <= 1'b1;
            end
          end
          if (scl_rise && in_tx) begin
            in_tx <= in_tx;
          end
        end
        i2c_slave_pkg::ST_HOLD: begin
          if (acc_release) begin
            hold <= 1'b0;
            state <= i2c_slave_pkg::ST_DATA;
            in_tx <= tx_mode;
            bitn <= 4'h0;
            shreg <= wr_dat ? wr_data : shreg;
            sda_low <= wr_dat && tx_mode && !wr_data[7];
          end
        end
        i2c_slave_pkg::ST_DATA: begin
          if (scl_rise) begin
            if (!in_tx) shreg <= {shreg[6:0], sda_f};
            bitn <= bitn + 4'h1;
          end
          if (scl_fall && in_tx) begin
            shreg <= {shreg[6:0], 1'b0};
            sda_low <= !shreg[6] && bitn != 4'h8;
          end
          if (scl_fall && bitn == 4'h8) begin
            state <= i2c_slave_pkg::ST_DACK;
            bitn <= 4'h0;
            sda_low <= !in_tx && !stat[`ST_ACKOUT];
          end
        end
        default: state <= i2c_slave_pkg::ST_IDLE;
      endcase
    end
  end

  // Open-drain drivers: only ever pull low
  assign sda_out = 1'b0;
  assign scl_out = 1'b0;
  assign sda_oe = active && sda_low;
  assign scl_oe = active && hold;

  // ==========================================================
  // Status flags
  // ==========================================================
  wire addr_done = state == i2c_slave_pkg::ST_ADDR
                   && scl_fall && bitn == 4'h8;
  wire match_ev = addr_done && addr_hit;
  wire data_done = state == i2c_slave_pkg::ST_DATA
                   && scl_fall && bitn == 4'h8;
  wire ack_sample = state == i2c_slave_pkg::ST_DACK && in_tx && scl_rise;
  wire byte_start = state == i2c_slave_pkg::ST_HOLD && acc_release;

  // Flags follow hardware events; software writes only control bits
  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      stat <= `STAT_RESET;
    end else begin
      if (wr_stat) begin
        stat[`ST_TX] <= wr_data[`ST_TX];
        stat[`ST_ACKOUT] <= wr_data[`ST_ACKOUT];
        stat[`ST_WAKE] <= wr_data[`ST_WAKE];
      end
      if (en_rise) begin
        stat[`ST_DONE] <= 1'b1;
        stat[`ST_MATCH] <= 1'b0;
        stat[`ST_BUSY] <= 1'b0;
        stat[`ST_DIR] <= 1'b0;
        stat[`ST_ACKIN] <= 1'b1;
      end else begin
        if (start_ev) stat[`ST_BUSY] <= 1'b1;
        else if (stop_ev) stat[`ST_BUSY] <= 1'b0;
        if (start_ev || byte_start) stat[`ST_DONE] <= 1'b0;
        else if (addr_done || data_done) stat[`ST_DONE] <= 1'b1;
        if (addr_done) begin
          stat[`ST_MATCH] <= addr_hit;
          stat[`ST_DIR] <= shreg[0];
        end else if (byte_start) begin
          stat[`ST_MATCH] <= 1'b0;
        end
        if (ack_sample) stat[`ST_ACKIN] <= sda_f;
      end
    end
  end

  // Data register and timeout flag
  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      data_reg <= 8'h00;
      own_addr <= 7'h00;
      ctrl <= `CTRL_RESET;
      tout_flag <= 1'b0;
    end else begin
      if (wr_dat) data_reg <= wr_data;
      else if (data_done && !in_tx) data_reg <= shreg;
      if (wr_own) own_addr <= wr_data[7:1];
      if (wr_ctrl) ctrl <= wr_data;
      if (wr_tout && !wr_data[`TOUT_FLAG]) tout_flag <= 1'b0;
    end
  end

  // One shared interrupt for match and byte done; the timeout flag ORed in is never set, only cleared
  logic irq_q;
  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) irq_q <= 1'b0;
    else irq_q <= active && (match_ev || data_done);
  end
  assign bus_irq = irq_q || tout_flag;

  // Wake on address match while enabled
  assign wake_req = irq_q && stat[`ST_WAKE] && stat[`ST_MATCH];

endmodule : i2c_slave_interface

// ===== core/i2c_slave_pkg.sv
package i2c_slave_pkg;

  // Bit engine states
  typedef enum logic [5:0] {
    ST_IDLE = 6'h01,
    ST_ADDR = 6'h02,
    ST_AACK = 6'h04,
    ST_HOLD = 6'h08,
    ST_DATA = 6'h10,
    ST_DACK = 6'h20
  } engine_state_t;

endpackage : i2c_slave_pkg

// ===== core/line_filter.sv
`timescale 1ns/100ps
`include "i2c_slave_cfg.svh"

// ============================================================
// Pin synchroniser with optional debounce
// ============================================================
module line_filter (
  // Clock and reset
  input wire logic mclk,
  input wire logic rstn,
  // Raw pin and debounce length
  input wire logic pin,
  input wire logic [2:0] deb_len,
  // Filtered level
  output logic level
);

  logic s1;
  logic s2;
  logic s3;
  logic [2:0] cnt;

  // Three-flop chain; only s2 and s3 are compared
  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      s1 <= 1'b1;
      s2 <= 1'b1;
      s3 <= 1'b1;
    end else begin
      s1 <= pin;
      s2 <= s1;
      s3 <= s2;
    end
  end

  // A new level must stand deb_len clocks before it is passed on
  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      cnt <= 3'h0;
      level <= 1'b1;
    end else if (s2 != s3 || s3 == level) begin
      cnt <= 3'h0;
    end else if (cnt >= deb_len) begin
      level <= s3;
      cnt <= 3'h0;
    end else begin
      cnt <= cnt + 3'h1;
    end
  end

endmodule : line_filter

// ===== verif/i2c_master_model.sv
`timescale 1ns/100ps
// ============================================================
// Bus master model; clock stands high between frames
// ============================================================
module i2c_master_model (
  // Wire levels
  input wire logic scl,
  input wire logic sda,
  // Pull-low enables
  output logic scl_pull,
  output logic sda_pull
);
  initial begin
    scl_pull = 1'b0;
    sda_pull = 1'b0;
  end
  // Data falls while the clock is high
  task start_frame;
    #100 sda_pull = 1'b1;
    #100 scl_pull = 1'b1;
  endtask : start_frame
  // 140 ns low, 60 ns high; the slave answers about five clocks after
  // it sees the fall, so its data must settle inside the low phase
  task bit_io(input logic b, output logic s);
    #70 sda_pull = !b;
    #70 scl_pull = 1'b0;
    wait (scl === 1'b1); // Slave may stretch the clock
    #50 s = sda;
    #10 scl_pull = 1'b1;
  endtask : bit_io
  // Address and data go out MSB first, ack read in ninth clock
  task send_byte(input logic [7:0] v, output logic ack);
    logic s;
    for (int i = 7; i >= 0; i--) begin
      bit_io(v[i], s);
    end
    bit_io(1'b1, ack);
    #150; // Slave takes its clock hold before software acts
  endtask : send_byte
  // Line released for the slave; ack level chosen by caller
  task recv_byte(input logic ack, output logic [7:0] v);
    logic s;
    for (int i = 7; i >= 0; i--) begin
      bit_io(1'b1, s);
      v[i] = s;
    end
    bit_io(ack, s);
    #150;
  endtask : recv_byte
  // Data rises while the clock is high
  task stop_frame;
    #80 sda_pull = 1'b1;
    #80 scl_pull = 1'b0;
    wait (scl === 1'b1);
    #100 sda_pull = 1'b0;
    #200;
  endtask : stop_frame
endmodule : i2c_master_model

// ===== verif/i2c_slave_checker.sv
`timescale 1ns/100ps
// ============================================================
// Port checks for the two-wire slave
// ============================================================
module i2c_slave_checker (
  // Clock and reset
  input wire logic mclk,
  input wire logic rstn,
  // Strap and register bus handshakes
  input wire logic option_enable,
  input wire logic [4:0] awaddr,
  input wire logic awvalid,
  input wire logic awready,
  input wire logic [4:0] araddr,
  input wire logic arvalid,
  input wire logic arready,
  // Pins and events
  input wire logic scl_in,
  input wire logic scl_oe,
  input wire logic sda_oe,
  input wire logic bus_irq,
  input wire logic wake_req,
  input wire logic low_power
);
  default clocking @(posedge mclk); endclocking
  default disable iff (!rstn);
  // Data register (offset 0x0C) accessed while the clock is held
  logic data_hit;
  logic data_touch;
  assign data_hit = (awvalid && awready && awaddr == 5'h0C) ||
                    (arvalid && arready && araddr == 5'h0C);
  // Cleared whenever the hold ends, so stale accesses never count
  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      data_touch <= 1'b0;
    end else begin
      data_touch <= scl_oe && (data_touch || data_hit);
    end
  end
  chk_pins_off: assert property (low_power |-> !scl_oe && !sda_oe)
    else $error("pins driven while inactive");
  chk_low_wake: assert property (low_power |-> !wake_req)
    else $error("wake request while inactive");
  chk_strap_off: assert property (
    !option_enable && !$past(option_enable) |-> low_power)
    else $error("active without strap");
  chk_hold_release: assert property (
    $fell(scl_oe) |-> data_touch || low_power)
    else $error("clock released without data access");
  chk_hold_start: assert property ($rose(scl_oe) |-> !$past(scl_in))
    else $error("clock hold began while clock high");
  chk_sda_clk_low: assert property (
    $changed(sda_oe) && !low_power |-> !$past(scl_in))
    else $error("data line moved while clock high");
  chk_wake_ack: assert property (wake_req |-> ##[0:40] sda_oe)
    else $error("wake without acknowledge");
  chk_irq_pulse: assert property ($rose(bus_irq) |=> !bus_irq)
    else $error("interrupt pulse too long");
  cov_wake: cover property (wake_req);
  cov_release: cover property ($fell(scl_oe));
  cov_irq: cover property ($rose(bus_irq));
endmodule : i2c_slave_checker

bind i2c_slave_interface i2c_slave_checker i_chk (
  .mclk(mclk), .rstn(rstn), .option_enable(option_enable),
  .awaddr(awaddr), .awvalid(awvalid), .awready(awready),
  .araddr(araddr), .arvalid(arvalid), .arready(arready),
  .scl_in(scl_in), .scl_oe(scl_oe), .sda_oe(sda_oe),
  .bus_irq(bus_irq), .wake_req(wake_req), .low_power(low_power)
);

// ===== verif/tb_top.sv
`timescale 1ns/100ps
`include "i2c_slave_cfg.svh"
// ============================================================
// Self-checking bench
// ============================================================
module tb_top;
  logic mclk = 1'b0, rstn = 1'b0, option_enable = 1'b1;
  logic [4:0] awaddr = 5'h00, araddr = 5'h00;
  logic [31:0] wdata = 32'h00000000;
  logic [3:0] wstrb = 4'hF;
  logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0;
  logic arvalid = 1'b0, rready = 1'b0;
  logic awready, wready, bvalid, arready, rvalid, ack;
  logic [1:0] bresp, rresp, r;
  logic [31:0] rdata, v;
  logic [7:0] d;
  logic scl_out, scl_oe, sda_out, sda_oe, m_scl, m_sda;
  logic bus_irq, wake_req, low_power;
  int mismatches = 0, n_compared = 0, irqs = 0, wakes = 0;
  // Open drain wires with pull-ups
  wire scl = !m_scl && !(scl_oe && !scl_out);
  wire sda = !m_sda && !(sda_oe && !sda_out);
  i2c_slave_interface i_dut (
    .mclk(mclk), .rstn(rstn), .option_enable(option_enable),
    .awaddr(awaddr), .awvalid(awvalid), .awready(awready),
    .wdata(wdata), .wstrb(wstrb), .wvalid(wvalid), .wready(wready),
    .bresp(bresp), .bvalid(bvalid), .bready(bready),
    .araddr(araddr), .arvalid(arvalid), .arready(arready),
    .rdata(rdata), .rresp(rresp), .rvalid(rvalid), .rready(rready),
    .scl_in(scl), .scl_out(scl_out), .scl_oe(scl_oe),
    .sda_in(sda), .sda_out(sda_out), .sda_oe(sda_oe),
    .bus_irq(bus_irq), .wake_req(wake_req), .low_power(low_power)
  );
  i2c_master_model i_bus (.scl(scl), .sda(sda), .scl_pull(m_scl),
    .sda_pull(m_sda));
  always #12.5 mclk = !mclk;
  // Event counters; pulses last one cycle so edges are counted
  always @(posedge mclk) begin
    irqs += (bus_irq === 1'b1);
    wakes += (wake_req === 1'b1);
  end
  task chk(input string w, input logic [31:0] e, input logic [31:0] g);
    n_compared++;
    if (g !== e) begin
      mismatches++;
      $display("[FAIL] %s expected %h seen %h", w, e, g);
    end
  endtask : chk
  task bchk(input string w, input logic e, input logic g);
    chk(w, {31'h0, e}, {31'h0, g});
  endtask : bchk
  // Handshakes judged at the falling edge, acted on at the next rise
  task wr(input logic [4:0] a, input logic [7:0] x);
    logic ha, hw, hb;
    @(posedge mclk);
    awaddr <= a;
    wdata <= {24'h000000, x};
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    hb = 1'b0;
    while (!hb) begin
      @(negedge mclk);
      ha = awvalid && awready;
      hw = wvalid && wready;
      hb = bvalid;
      r = bresp;
      @(posedge mclk);
      if (ha) awvalid <= 1'b0;
      if (hw) wvalid <= 1'b0;
    end
    bready <= 1'b0;
    chk("write resp", (a > `OFS_TOUT) ? 32'h2 : 32'h0, {30'h0, r});
  endtask : wr
  task rd(input logic [4:0] a);
    logic ha, hr;
    @(posedge mclk);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    hr = 1'b0;
    while (!hr) begin
      @(negedge mclk);
      ha = arvalid && arready;
      hr = rvalid;
      v = rdata;
      r = rresp;
      @(posedge mclk);
      if (ha) arvalid <= 1'b0;
    end
    rready <= 1'b0;
    chk("read resp", (a > `OFS_TOUT) ? 32'h2 : 32'h0, {30'h0, r});
  endtask : rd
  task rchk(input string w, input logic [4:0] a, input logic [7:0] e,
    input logic [7:0] m);
    rd(a);
    chk(w, {24'h000000, e & m}, v & {24'hFFFFFF, m});
  endtask : rchk
  task t_reset;
    bchk("low_power", 1'b1, low_power);
    rchk("ctrl", `OFS_CTRL, 8'hE0, 8'hFF);
    rchk("status", `OFS_STAT, 8'h81, 8'hFF);
    rchk("timeout", `OFS_TOUT, 8'h00, 8'hFF);
    rd(5'h14);
    chk("unmapped rdata", 32'h0, v);
    chk("unmapped rresp", 32'h2, {30'h0, r});
    wr(5'h14, 8'hFF);
    chk("unmapped bresp", 32'h2, {30'h0, r});
  endtask : t_reset
  task t_setup;
    option_enable <= 1'b0;
    wr(`OFS_CTRL, 8'hC2);
    wr(`OFS_ADDR, 8'hB5);
    repeat (4) @(posedge mclk);
    bchk("strap off", 1'b1, low_power);
    option_enable <= 1'b1;
    repeat (4) @(posedge mclk);
    bchk("active", 1'b0, low_power);
    rchk("own addr", `OFS_ADDR, 8'hB4, 8'hFF);
  endtask : t_setup
  task t_miss;
    i_bus.start_frame;
    i_bus.send_byte(8'hB6, ack);
    bchk("miss ack", 1'b1, ack);
    rchk("miss flags", `OFS_STAT, 8'h20, 8'h60);
    i_bus.stop_frame;
    rchk("stop busy", `OFS_STAT, 8'h00, 8'h20);
  endtask : t_miss
  task t_write;
    wr(`OFS_STAT, 8'h02);
    irqs = 0;
    wakes = 0;
    i_bus.start_frame;
    i_bus.send_byte(8'hB4, ack);
    bchk("addr ack", 1'b0, ack);
    rchk("match flags", `OFS_STAT, 8'h60, 8'h64);
    bchk("clock held", 1'b1, scl_oe);
    chk("wake", 32'h1, wakes);
    chk("irq", 32'h1, irqs);
    wr(`OFS_STAT, 8'h00);
    rd(`OFS_DATA);
    repeat (4) @(posedge mclk);
    bchk("clock free", 1'b0, scl_oe);
    i_bus.send_byte(8'hA5, ack);
    bchk("data ack", 1'b0, ack);
    rchk("done", `OFS_STAT, 8'h80, 8'h80);
    rchk("rx data", `OFS_DATA, 8'hA5, 8'hFF);
    chk("irq", 32'h2, irqs);
    wr(`OFS_STAT, 8'h08);
    i_bus.send_byte(8'h3C, ack);
    bchk("no ack", 1'b1, ack);
    rchk("rx data", `OFS_DATA, 8'h3C, 8'hFF);
    i_bus.stop_frame;
  endtask : t_write
  task t_read;
    i_bus.start_frame;
    i_bus.send_byte(8'hB5, ack);
    rchk("dir read", `OFS_STAT, 8'h04, 8'h04);
    wr(`OFS_STAT, 8'h10);
    wr(`OFS_DATA, 8'hC3);
    i_bus.recv_byte(1'b0, d);
    chk("tx byte", 32'hC3, {24'h0, d});
    rchk("ack in", `OFS_STAT, 8'h00, 8'h01);
    wr(`OFS_DATA, 8'h5A);
    i_bus.recv_byte(1'b1, d);
    chk("tx byte", 32'h5A, {24'h0, d});
    rchk("nack in", `OFS_STAT, 8'h01, 8'h01);
    bchk("sda free", 1'b0, sda_oe);
    wr(`OFS_STAT, 8'h00);
    rd(`OFS_DATA);
    i_bus.stop_frame;
    rchk("idle", `OFS_STAT, 8'h00, 8'h20);
  endtask : t_read
  // Disable in mid-frame, then enable: controls kept, flags reset
  task t_enable;
    wr(`OFS_STAT, 8'h18);
    i_bus.start_frame;
    i_bus.send_byte(8'hB6, ack);
    wr(`OFS_CTRL, 8'hC0);
    repeat (2) @(posedge mclk);
    bchk("off", 1'b1, low_power);
    chk("off pins", 32'h0, {30'h0, scl_oe, sda_oe});
    i_bus.stop_frame;
    wr(`OFS_CTRL, 8'hC2);
    rchk("enable rise", `OFS_STAT, 8'h99, 8'hFF);
  endtask : t_enable
  task stop_test;
    $display("compared %0d mismatches %0d", n_compared, mismatches);
    if (mismatches == 0 && n_compared > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask : stop_test
  initial begin
    repeat (5) @(posedge mclk);
    rstn <= 1'b1;
    t_reset;
    t_setup;
    t_miss;
    t_write;
    t_read;
    t_enable;
    stop_test;
  end
  // A run of a few frames needs well under this span
  initial begin
    #400000;
    mismatches++;
    stop_test;
  end
endmodule : tb_top
